// *** rtl/pmd_consts.svh ***
// constant map for the program/data decoder and register bank
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH
// ====================================================================
// program space
`define PMD_LOWER_BASE  16'h0000
`define PMD_UPPER_BASE  16'hf000
`define PMD_ROW_LSB     6
`define PMD_UP_ROW_LSB  5
`define PMD_UP_ROW_W    7
`define PMD_UP_ROWS     10'h080
`define PMD_UP_COLS     6'h20
`define PMD_ROWS_PER_KB 16
`define PMD_KB_BYTES    1024
// ====================================================================
// register bank
`define PMD_NSFR        33
`define PMD_IRAM_DEPTH  256
`define PMD_IDX_FLASH_COMMAND_MAILBOX    18
`define PMD_IDX_FLASH_ADDRESS_LOW_MAILBOX    19
`define PMD_IDX_FLASH_ADDRESS_HIGH_MAILBOX    20
`define PMD_IDX_FLASH_DATA_MAILBOX    21
`define PMD_IDX_FLASH_CONFIGURATION_MAILBOX    22
`define PMD_VIS_BIT     7
`define PMD_BUSY_BIT    3
`define PMD_FLASH_CONFIGURATION_MAILBOX_WMASK  8'he0
`define PMD_ZERO8       8'h00
`define PMD_SFR_ADDRS {8'h80, 8'h81, 8'h82, 8'h83, 8'h86, 8'h87, \
	8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h98, 8'h99, \
	8'ha0, 8'ha8, 8'hb0, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb8, \
	8'hc0, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0}
`define PMD_SFR_RST {8'hff, 8'h07, {10{8'h00}}, 8'hff, 8'h00, \
	8'h00, 8'hff, 8'h00, 8'hff, {15{8'h00}}}
`endif

// *** rtl/pmd_pkg.sv ***
// shared types for the program/data decoder and register bank
`default_nettype none
`include "pmd_consts.svh"
package pmd_pkg;
	typedef enum logic [1:0] {
		PMD_SPACE_IRAM = 2'h0,
		PMD_SPACE_XRAM = 2'h1,
		PMD_SPACE_SFR  = 2'h2
	} pmd_space_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} pmd_fetch_req_t;

	typedef struct packed {
		logic        lower;
		logic        upper;
		logic        ext;
		logic [15:0] addr;
		logic [9:0]  row;
		logic [5:0]  col;
	} pmd_fetch_rsp_t;

	typedef struct packed {
		logic        valid;
		pmd_space_t  space;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pmd_data_req_t;

	typedef struct packed {
		logic        rvalid;
		logic [7:0]  rdata;
		logic        ext_sel;
		logic        ext_we;
		logic [15:0] ext_addr;
		logic [7:0]  ext_wdata;
	} pmd_data_rsp_t;

	typedef struct packed {
		logic        stb;
		logic        hit;
		logic        upper;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [9:0]  row;
		logic [5:0]  col;
	} pmd_flash_req_t;

	typedef struct packed {
		logic                          ea_meta;
		logic                          ea_sync;
		logic [0:`PMD_NSFR-1][7:0]     sfr;
		logic                          rd_valid;
		logic                          rd_iram;
		logic [7:0]                    rd_sfr;
		pmd_fetch_rsp_t                fetch_rsp;
		pmd_data_rsp_t                 data_rsp;
		pmd_flash_req_t                flash_req;
	} pmd_state_t;
endpackage
`default_nettype wire

// *** rtl/pmd_flash_geom.sv ***
// row and column split of a flash address for both blocks
`default_nettype none
`include "pmd_consts.svh"
module pmd_flash_geom #(
	parameter int LOWER_ROW_W = 10
) (
	// program address
	input  wire logic [15:0] addr,
	// decoded array position
	output logic             in_upper,
	output logic [9:0]       row,
	output logic [5:0]       col
);
	always_comb begin
		in_upper = addr >= `PMD_UPPER_BASE;
		if (in_upper) begin
			// 32-byte rows, 7 row lines
			row = 10'(addr[`PMD_UP_ROW_LSB +: `PMD_UP_ROW_W]);
			col = 6'(addr[`PMD_UP_ROW_LSB-1:0]);
		end else begin
			// 64-byte rows, 8/9/10 row lines
			row = 10'(addr[`PMD_ROW_LSB +: LOWER_ROW_W]);
			col = addr[`PMD_ROW_LSB-1:0];
		end
	end
endmodule // pmd_flash_geom
`default_nettype wire

// *** rtl/pmd_ram.sv ***
// internal data memory with registered read
`default_nettype none
module pmd_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and enable
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// access port
	input  wire logic             we,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// array has no reset: contents undefined until written
	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
	end

	// read during write returns the old byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (ce) begin
			rdata_q <= mem[addr];
		end
	end
endmodule // pmd_ram
`default_nettype wire

// *** rtl/pmd_map_decode.sv ***
// program/data space decoder with register bank and flash mailbox
// Function
// - lower flash block spans zero to 3FFF, 7FFF or EFFF by size
// - upper 4 KByte flash block spans F000 to FFFF in every size
// - after reset the upper block is hidden from fetches, even internally
// - mailbox registers always reach the upper block for programming
// - setting bit 7 of register B6 makes the upper block fetchable
// - lower block fetchable only while the pin is high; boot runs there then
// - 16 KByte array: 256 rows, 8 row lines, 6 column lines
// - 32 KByte array: 512 rows, 9 row lines, 6 column lines
// - 60 KByte array: 960 rows, 10 row lines, 6 column lines
// - 4 KByte array: 128 rows, 7 row lines, 5 column lines
// - program and data spaces are chosen by access type, not address
// - 256 bytes internal RAM plus 64 KByte external data space
`default_nettype none
`include "pmd_consts.svh"
module pmd_map_decode #(
	parameter int LOWER_KB = 60
) (
	// clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	// pin: high lets the internal flash execute
	input  wire logic                    external_access_enable_n,
	// instruction fetch
	input  wire pmd_pkg::pmd_fetch_req_t fetch_req,
	output var  pmd_pkg::pmd_fetch_rsp_t fetch_rsp_q,
	// data and register access
	input  wire pmd_pkg::pmd_data_req_t  data_req,
	output var  pmd_pkg::pmd_data_rsp_t  data_rsp_q,
	// flash programming engine
	input  wire logic                    flash_busy,
	output var  pmd_pkg::pmd_flash_req_t flash_req_q,
	// status
	output logic                         upper_block_fetch_visible_q
);
	// ====================================================================
	// geometry
	localparam logic [15:0] LOWER_TOP =
		16'(LOWER_KB * `PMD_KB_BYTES - 1);
	localparam int LROW_W = $clog2(LOWER_KB * `PMD_ROWS_PER_KB);
	localparam logic [9:0] LOWER_ROWS =
		10'(LOWER_KB * `PMD_ROWS_PER_KB);
	localparam logic [0:`PMD_NSFR-1][7:0] SFR_ADDRS =
		`PMD_SFR_ADDRS;
	localparam logic [0:`PMD_NSFR-1][7:0] SFR_RST = `PMD_SFR_RST;

	// ====================================================================
	// declarations
	pmd_pkg::pmd_state_t s_q;
	pmd_pkg::pmd_state_t s_d;
	logic [`PMD_NSFR-1:0] sfr_hit;
	logic                 sfr_wr;
	logic                 sfr_rd;
	logic [7:0]           sfr_rdata;
	logic                 ram_we;
	logic [7:0]           ram_rdata;
	logic                 upper_block_fetch_visible;
	logic                 fetch_upper;
	logic [9:0]           fetch_row;
	logic [5:0]           fetch_col;
	logic [15:0]          mb_addr;
	logic                 mb_upper;
	logic [9:0]           mb_row;
	logic [5:0]           mb_col;

	// ====================================================================
	// register decode
	// only the low address byte selects a register
	for (genvar i = 0; i < `PMD_NSFR; i++) begin : g_hit
		assign sfr_hit[i] = data_req.addr[7:0] == SFR_ADDRS[i];
	end

	// the access type alone picks the space
	assign sfr_wr = data_req.valid && data_req.we &&
		data_req.space == pmd_pkg::PMD_SPACE_SFR;
	assign sfr_rd = data_req.valid && !data_req.we &&
		data_req.space == pmd_pkg::PMD_SPACE_SFR;
	assign ram_we = data_req.valid && data_req.we &&
		data_req.space == pmd_pkg::PMD_SPACE_IRAM;

	assign upper_block_fetch_visible = s_q.sfr[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX][`PMD_VIS_BIT];
	assign mb_addr = {s_q.sfr[`PMD_IDX_FLASH_ADDRESS_HIGH_MAILBOX], s_q.sfr[`PMD_IDX_FLASH_ADDRESS_LOW_MAILBOX]};

	// ====================================================================
	// array geometry
	// smaller parts leave a gap below the upper block; it decodes as ext
	pmd_flash_geom #(
		.LOWER_ROW_W(LROW_W)
	) u_fetch_geom (
		.addr    (fetch_req.addr),
		.in_upper(fetch_upper),
		.row     (fetch_row),
		.col     (fetch_col)
	);

	pmd_flash_geom #(
		.LOWER_ROW_W(LROW_W)
	) u_mbox_geom (
		.addr    (mb_addr),
		.in_upper(mb_upper),
		.row     (mb_row),
		.col     (mb_col)
	);

	// ====================================================================
	// internal data memory
	// writes and reads are frozen by ce inside the memory as well
	pmd_ram #(
		.WIDTH(8),
		.DEPTH(`PMD_IRAM_DEPTH)
	) u_iram (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.we     (ram_we),
		.addr   (data_req.addr[7:0]),
		.wdata  (data_req.wdata),
		.rdata_q(ram_rdata)
	);

	// ====================================================================
	// next state
	always_comb begin
		s_d = s_q;
		// pin passes two flops before any use
		s_d.ea_meta = external_access_enable_n;
		s_d.ea_sync = s_q.ea_meta;

		// fetch routing, one-cycle answer
		// the pin arrives through the sync, so a change lands two edges late
		s_d.fetch_rsp.lower = 1'b0;
		s_d.fetch_rsp.upper = 1'b0;
		s_d.fetch_rsp.ext = 1'b0;
		if (fetch_req.valid) begin
			s_d.fetch_rsp.addr = fetch_req.addr;
			s_d.fetch_rsp.row = fetch_row;
			s_d.fetch_rsp.col = fetch_col;
			if (!s_q.ea_sync) begin
				s_d.fetch_rsp.ext = 1'b1;
			end else if (fetch_req.addr <= LOWER_TOP) begin
				s_d.fetch_rsp.lower = 1'b1;
			end else if (fetch_upper && upper_block_fetch_visible) begin
				s_d.fetch_rsp.upper = 1'b1;
			end else begin
				// hidden upper block and size gaps go off chip
				s_d.fetch_rsp.ext = 1'b1;
			end
		end

		// register writes
		for (int i = 0; i < `PMD_NSFR; i++) begin
			if (sfr_wr && sfr_hit[i]) begin
				s_d.sfr[i] = data_req.wdata;
			end
		end
		// only the top three bits hold; busy is live status
		if (sfr_wr && sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX]) begin
			s_d.sfr[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX] =
				(data_req.wdata & `PMD_FLASH_CONFIGURATION_MAILBOX_WMASK) |
				(s_q.sfr[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX] & ~`PMD_FLASH_CONFIGURATION_MAILBOX_WMASK);
		end

		// register reads; unmapped offsets read zero
		sfr_rdata = `PMD_ZERO8;
		for (int i = 0; i < `PMD_NSFR; i++) begin
			if (sfr_hit[i]) begin
				sfr_rdata = s_q.sfr[i];
			end
		end
		if (sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX]) begin
			sfr_rdata[`PMD_BUSY_BIT] = flash_busy;
		end

		// read pipeline: ram has its own register, so two stages
		// space 3 reads are answered with zero; callers must not use it
		s_d.rd_valid = data_req.valid && !data_req.we &&
			data_req.space != pmd_pkg::PMD_SPACE_XRAM;
		s_d.rd_iram = data_req.space == pmd_pkg::PMD_SPACE_IRAM;
		s_d.rd_sfr = sfr_rd ? sfr_rdata : `PMD_ZERO8;
		s_d.data_rsp.rvalid = s_q.rd_valid;
		if (s_q.rd_valid) begin
			s_d.data_rsp.rdata = s_q.rd_iram ? ram_rdata : s_q.rd_sfr;
		end

		// external data space, full 16-bit address
		s_d.data_rsp.ext_sel = data_req.valid &&
			data_req.space == pmd_pkg::PMD_SPACE_XRAM;
		if (s_d.data_rsp.ext_sel) begin
			s_d.data_rsp.ext_we = data_req.we;
			s_d.data_rsp.ext_addr = data_req.addr;
			s_d.data_rsp.ext_wdata = data_req.wdata;
		end

		// mailbox command: reaches either block, visible or not
		// fields latch only with the strobe so the engine may take them late
		s_d.flash_req.stb = 1'b0;
		if (sfr_wr && sfr_hit[`PMD_IDX_FLASH_COMMAND_MAILBOX]) begin
			s_d.flash_req.stb = 1'b1;
			s_d.flash_req.cmd = data_req.wdata;
			s_d.flash_req.addr = mb_addr;
			s_d.flash_req.data = s_q.sfr[`PMD_IDX_FLASH_DATA_MAILBOX];
			s_d.flash_req.upper = mb_upper;
			s_d.flash_req.hit = mb_upper || mb_addr <= LOWER_TOP;
			s_d.flash_req.row = mb_row;
			s_d.flash_req.col = mb_col;
		end
	end

	// ====================================================================
	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.sfr <= SFR_RST;
			// sync starts high so the boot fetch is not sent off chip early
			s_q.ea_meta <= 1'b1;
			s_q.ea_sync <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign fetch_rsp_q = s_q.fetch_rsp;
	assign data_rsp_q = s_q.data_rsp;
	assign flash_req_q = s_q.flash_req;
	assign upper_block_fetch_visible_q = upper_block_fetch_visible;

	// ====================================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// fetch_go mirrors the routing gate, so a low pin masks these checks
	logic fetch_go;
	logic fetch_hi;
	assign fetch_go = ce && fetch_req.valid && s_q.ea_sync;
	assign fetch_hi = fetch_req.addr >= `PMD_UPPER_BASE;

	lower_map_a: assert property (
		fetch_go && fetch_req.addr <= LOWER_TOP
		|=> fetch_rsp_q.lower && !fetch_rsp_q.ext &&
		fetch_rsp_q.col == $past(fetch_req.addr[5:0]))
	else $error("lower block fetch not routed inside");

	upper_map_a: assert property (
		fetch_go && fetch_hi && upper_block_fetch_visible
		|=> fetch_rsp_q.upper &&
		fetch_rsp_q.row == 10'($past(fetch_req.addr[11:5])))
	else $error("visible upper fetch not routed inside");

	upper_hidden_a: assert property (
		fetch_go && fetch_hi && !upper_block_fetch_visible |=> !fetch_rsp_q.upper)
	else $error("hidden upper block answered a fetch");

	mbox_reach_a: assert property (
		ce && sfr_wr && sfr_hit[`PMD_IDX_FLASH_COMMAND_MAILBOX] && mb_upper
		|=> flash_req_q.stb && flash_req_q.upper && flash_req_q.hit)
	else $error("mailbox command lost the upper block");

	vis_cause_a: assert property (
		$rose(upper_block_fetch_visible) |-> $past(sfr_wr && ce &&
		sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX] && data_req.wdata[`PMD_VIS_BIT]))
	else $error("visibility rose without a config write");

	boot_lower_a: assert property (
		fetch_go && fetch_req.addr == `PMD_LOWER_BASE
		|=> fetch_rsp_q.lower)
	else $error("reset address not fetched from lower block");

	lower_rows_a: assert property (
		fetch_rsp_q.lower |-> fetch_rsp_q.row < LOWER_ROWS)
	else $error("lower row index out of array");

	upper_rows_a: assert property (
		fetch_rsp_q.upper |->
		fetch_rsp_q.row < `PMD_UP_ROWS && fetch_rsp_q.col < `PMD_UP_COLS)
	else $error("upper row or column out of array");

	space_sel_a: assert property (
		ce && data_req.valid &&
		data_req.space == pmd_pkg::PMD_SPACE_XRAM
		|=> data_rsp_q.ext_sel &&
		data_rsp_q.ext_addr == $past(data_req.addr))
	else $error("external data access not routed off chip");

	iram_read_a: assert property (
		ce && data_req.valid && !data_req.we &&
		data_req.space == pmd_pkg::PMD_SPACE_IRAM ##1 ce
		|=> data_rsp_q.rvalid && !$past(data_rsp_q.ext_sel))
	else $error("internal ram read gave no answer");

	ext_hidden_a: assert property (
		fetch_go && fetch_hi && !upper_block_fetch_visible |=> fetch_rsp_q.ext)
	else $error("hidden upper fetch not sent off chip");

	fetch_onehot_a: assert property (
		$onehot0({fetch_rsp_q.lower, fetch_rsp_q.upper, fetch_rsp_q.ext}))
	else $error("fetch answered by more than one target");

	pin_low_ext_a: assert property (
		ce && fetch_req.valid && !s_q.ea_sync
		|=> fetch_rsp_q.ext && !fetch_rsp_q.lower)
	else $error("fetch with pin low stayed on chip");

	vis_follow_a: assert property (
		ce && sfr_wr && sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX]
		|=> upper_block_fetch_visible_q ==
		$past(data_req.wdata[`PMD_VIS_BIT]))
	else $error("visibility did not follow the config write");

	vis_hold_a: assert property (
		!(ce && sfr_wr && sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX]) |=> $stable(upper_block_fetch_visible))
	else $error("visibility changed without a config write");

	mbox_gap_a: assert property (
		ce && sfr_wr && sfr_hit[`PMD_IDX_FLASH_COMMAND_MAILBOX] &&
		!mb_upper && mb_addr > LOWER_TOP
		|=> flash_req_q.stb && !flash_req_q.hit)
	else $error("mailbox address in the gap marked as a hit");

	mbox_lower_a: assert property (
		ce && sfr_wr && sfr_hit[`PMD_IDX_FLASH_COMMAND_MAILBOX] && mb_addr <= LOWER_TOP
		|=> flash_req_q.hit && !flash_req_q.upper &&
		flash_req_q.addr == $past(mb_addr))
	else $error("mailbox command lost the lower block");

	xram_no_rd_a: assert property (
		ce && data_req.valid && data_req.space == pmd_pkg::PMD_SPACE_XRAM
		##1 ce |=> !data_rsp_q.rvalid)
	else $error("external data access answered from inside");

	cfg_read_a: assert property (
		ce && sfr_rd && sfr_hit[`PMD_IDX_FLASH_CONFIGURATION_MAILBOX] ##1 ce
		|=> data_rsp_q.rvalid &&
		data_rsp_q.rdata[`PMD_BUSY_BIT] == $past(flash_busy, 2))
	else $error("config read lost the busy status");

	ce_freeze_a: assert property (
		!ce |=> $stable(s_q))
	else $error("state moved while the clock enable was low");

	lower_fetch_c: cover property (fetch_rsp_q.lower);
	upper_fetch_c: cover property (fetch_rsp_q.upper);
	hidden_fetch_c: cover property (fetch_rsp_q.ext && !upper_block_fetch_visible);
	mbox_upper_c: cover property (flash_req_q.stb && flash_req_q.upper);
	iram_read_c: cover property (data_rsp_q.rvalid);
endmodule // pmd_map_decode
`default_nettype wire

// *** tb/pmd_cpu_model.sv ***
// cpu-side model that issues fetch, data and register requests
`default_nettype none
module pmd_cpu_model (
	// clock
	input  wire logic                    clk,
	// answers
	input  wire pmd_pkg::pmd_data_rsp_t  data_rsp_q,
	// requests
	output var  pmd_pkg::pmd_fetch_req_t fetch_req,
	output var  pmd_pkg::pmd_data_req_t  data_req
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		fetch_req = '0;
		data_req  = '0;
	end

	// ====================================================================
	// requests rise after an edge and drop after the edge that takes them
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		fetch_req <= '{1'b1, a};
		@(posedge clk);
		fetch_req.valid <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [1:0] sp, input logic [15:0] a,
			input logic [7:0] v);
		@(posedge clk);
		data_req <= '{1'b1, pmd_pkg::pmd_space_t'(sp), 1'b1, a, v};
		@(posedge clk);
		data_req.valid <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [1:0] sp, input logic [15:0] a,
			output logic [7:0] v);
		int i;
		v = 8'hxx;
		@(posedge clk);
		data_req <= '{1'b1, pmd_pkg::pmd_space_t'(sp), 1'b0, a, 8'h00};
		@(posedge clk);
		data_req.valid <= 1'b0;
		// bounded wait: a missing answer leaves v unknown, so compares fail
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			if (data_rsp_q.rvalid === 1'b1) begin
				v = data_rsp_q.rdata;
				break;
			end
		end
	endtask
endmodule // pmd_cpu_model
`default_nettype wire

// *** tb/program_memory_map_and_sfr_decode_tb.sv ***
// bench for the program/data decoder across the three lower-block sizes
`default_nettype none
module program_memory_map_and_sfr_decode_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic                    clk   = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    ce    = 1'b1;
	logic                    pin   = 1'b0;
	logic                    busy  = 1'b0;
	logic                    upper_block_fetch_visible;
	logic [7:0]              d;
	pmd_pkg::pmd_fetch_req_t fetch_req;
	pmd_pkg::pmd_data_req_t  data_req;
	pmd_pkg::pmd_fetch_rsp_t frsp [3];
	pmd_pkg::pmd_data_rsp_t  drsp;
	pmd_pkg::pmd_flash_req_t freq;
	pmd_pkg::pmd_flash_req_t freq16;
	int                      n_errors = 0;
	int                      n_tests  = 0;
	logic [15:0]             top [3] = '{16'h3fff, 16'h7fff, 16'hefff};
	logic [7:0]              ra [7] = '{8'h80, 8'h81, 8'h82, 8'hb6, 8'hb2,
		8'he0, 8'h84};
	logic [7:0]              rv [7] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	always #10 clk = ~clk;

	// ====================================================================
	// design under test: 60 KByte part plus 16 and 32 KByte fetch decoders
	pmd_cpu_model i_pmd_cpu_model (
		.clk        (clk),
		.data_rsp_q (drsp),
		.fetch_req  (fetch_req),
		.data_req   (data_req)
	);
	pmd_map_decode #(.LOWER_KB(60)) i_pmd_map_decode (
		.clk(clk), .rst_n(rst_n), .ce(ce), .external_access_enable_n(pin),
		.fetch_req(fetch_req), .fetch_rsp_q(frsp[2]), .data_req(data_req),
		.data_rsp_q(drsp), .flash_busy(busy), .flash_req_q(freq),
		.upper_block_fetch_visible_q(upper_block_fetch_visible)
	);
	pmd_map_decode #(.LOWER_KB(16)) i_pmd_map_decode_16 (
		.clk(clk), .rst_n(rst_n), .ce(ce), .external_access_enable_n(pin),
		.fetch_req(fetch_req), .fetch_rsp_q(frsp[0]), .data_req(data_req),
		.data_rsp_q(), .flash_busy(busy), .flash_req_q(freq16),
		.upper_block_fetch_visible_q()
	);
	pmd_map_decode #(.LOWER_KB(32)) i_pmd_map_decode_32 (
		.clk(clk), .rst_n(rst_n), .ce(ce), .external_access_enable_n(pin),
		.fetch_req(fetch_req), .fetch_rsp_q(frsp[1]), .data_req(data_req),
		.data_rsp_q(), .flash_busy(busy), .flash_req_q(),
		.upper_block_fetch_visible_q()
	);

	// ====================================================================
	// compare and verdict
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [15:0] sel(input int j);
		return 16'({frsp[j].lower, frsp[j].upper, frsp[j].ext});
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	// ====================================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 7; i++) begin
			i_pmd_cpu_model.rd(2'h2, 16'(ra[i]), d);
			check("reset value", 16'(d), 16'(rv[i]));
		end
		check("visible at reset", 16'(upper_block_fetch_visible), 16'h0000);
		// pin low: even the lower block goes outside
		i_pmd_cpu_model.fetch(16'h0000);
		check("fetch pin low", sel(2), 16'h0001);
		@(posedge clk);
		pin <= 1'b1;
		repeat (3) @(posedge clk);
		// each lower top against every size: inside gives row/col, else ext
		for (int k = 0; k < 3; k++) begin
			i_pmd_cpu_model.fetch(top[k]);
			for (int j = 0; j < 3; j++) begin
				if (top[k] <= top[j]) begin
					check("lower sel", sel(j), 16'h0004);
					check("lower row", 16'(frsp[j].row),
						top[k] >> 6);
					check("lower col", 16'(frsp[j].col),
						16'h003f);
				end else begin
					check("gap sel", sel(j), 16'h0001);
				end
			end
		end
		// enable low freezes the answer pulse and drops new requests
		fork
			i_pmd_cpu_model.fetch(16'h0140);
			begin
				repeat (2) @(posedge clk);
				ce <= 1'b0;
			end
		join
		i_pmd_cpu_model.fetch(16'h0200);
		check("frozen sel", sel(2), 16'h0004);
		check("frozen addr", frsp[2].addr, 16'h0140);
		check("frozen row", 16'(frsp[0].row), 16'h0005);
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		#1;
		check("pulse ends", sel(2), 16'h0000);
		i_pmd_cpu_model.fetch(16'hf000);
		check("hidden upper", sel(2), 16'h0001);
		// mailbox reaches the upper block while it is hidden
		i_pmd_cpu_model.wr(2'h2, 16'h00b4, 8'hf0);
		i_pmd_cpu_model.wr(2'h2, 16'h00b3, 8'h40);
		i_pmd_cpu_model.wr(2'h2, 16'h00b5, 8'h5a);
		i_pmd_cpu_model.wr(2'h2, 16'h00b2, 8'h0b);
		check("mbox stb",
			16'({freq.stb, freq.hit, freq.upper}), 16'h0007);
		check("mbox addr", freq.addr, 16'hf040);
		check("mbox cmd data", {freq.cmd, freq.data}, 16'h0b5a);
		check("mbox row", 16'(freq.row), 16'h0002);
		check("mbox col", 16'(freq.col), 16'h0000);
		// a lower address reaches the 60 KByte part, misses the 16 KByte one
		i_pmd_cpu_model.wr(2'h2, 16'h00b4, 8'h80);
		i_pmd_cpu_model.wr(2'h2, 16'h00b2, 8'h0c);
		check("mbox lower",
			16'({freq.stb, freq.hit, freq.upper}), 16'h0006);
		check("mbox lower row", 16'(freq.row), 16'h0201);
		check("mbox gap",
			16'({freq16.stb, freq16.hit, freq16.upper}), 16'h0004);
		// configuration bit 7 opens the upper block
		i_pmd_cpu_model.wr(2'h2, 16'h00b6, 8'hff);
		check("visible set", 16'(upper_block_fetch_visible), 16'h0001);
		@(posedge clk);
		busy <= 1'b1;
		i_pmd_cpu_model.rd(2'h2, 16'h00b6, d);
		check("config read", 16'(d), 16'h00e8);
		i_pmd_cpu_model.fetch(16'hf000);
		check("upper sel", sel(2), 16'h0002);
		i_pmd_cpu_model.fetch(16'hffff);
		check("upper sel top", sel(2), 16'h0002);
		check("upper row", 16'(frsp[2].row), 16'h007f);
		check("upper col", 16'(frsp[2].col), 16'h001f);
		i_pmd_cpu_model.wr(2'h2, 16'h00b6, 8'h00);
		i_pmd_cpu_model.fetch(16'hf000);
		check("hidden again", sel(2), 16'h0001);
		// data spaces are told apart by access type
		i_pmd_cpu_model.wr(2'h0, 16'h0005, 8'ha5);
		i_pmd_cpu_model.wr(2'h0, 16'h00ff, 8'h3c);
		i_pmd_cpu_model.rd(2'h0, 16'h0005, d);
		check("ram read", 16'(d), 16'h00a5);
		i_pmd_cpu_model.rd(2'h0, 16'h00ff, d);
		check("ram top read", 16'(d), 16'h003c);
		i_pmd_cpu_model.rd(2'h2, 16'h0005, d);
		check("register space", 16'(d), 16'h0000);
		i_pmd_cpu_model.wr(2'h1, 16'hfffe, 8'h3c);
		check("ext sel we",
			16'({drsp.ext_sel, drsp.ext_we}), 16'h0003);
		check("ext addr", drsp.ext_addr, 16'hfffe);
		check("ext data", 16'(drsp.ext_wdata), 16'h003c);
		test_done();
	end
endmodule // program_memory_map_and_sfr_decode_tb
`default_nettype wire
